// ### hw/ttm_pkg.sv
/*
  ttm_pkg: register offsets, field positions, reset values and
  timing counts for the timer-two mode and control block.
  assumes an 8-bit special-function register port on ref_clk.
*/
package ttm_pkg;
  // register addresses
  localparam logic [7:0] CTRL_ADDR = 8'hC8;
  localparam logic [7:0] MODE_ADDR = 8'hC9;
  localparam logic [7:0] CAPL_ADDR = 8'hCA;
  localparam logic [7:0] CAPH_ADDR = 8'hCB;
  localparam logic [7:0] CNTL_ADDR = 8'hCC;
  localparam logic [7:0] CNTH_ADDR = 8'hCD;
  // control fields
  localparam int CTRL_OVF_FLAG   = 7;
  localparam int CTRL_EXT_FLAG   = 6;
  localparam int CTRL_RX_SEL     = 5;
  localparam int CTRL_TX_SEL     = 4;
  localparam int CTRL_TRIG_EN    = 3;
  localparam int CTRL_RUN        = 2;
  localparam int CTRL_SRC        = 1;
  localparam int CTRL_CAPSEL     = 0;
  // mode fields
  localparam int MODE_OUT_EN     = 1;
  localparam int MODE_DOWN_EN    = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;
  // machine-cycle divider: osc/12 or osc/6
  localparam int CYC_12CLK = 12;
  localparam int CYC_6CLK  = 6;
  // baud-generator divider: osc/2 in 12-clock, osc in 6-clock
  localparam int BAUD_12CLK = 2;
  localparam int BAUD_6CLK  = 1;
  localparam logic [3:0] DIV_12 = 4'(CYC_12CLK - 1);
  localparam logic [3:0] DIV_6  = 4'(CYC_6CLK - 1);
  localparam logic [3:0] BDIV_12 = 4'(BAUD_12CLK - 1);
  localparam logic [3:0] BDIV_6  = 4'(BAUD_6CLK - 1);
  // pin edge detector states
  typedef enum logic [1:0] {
    EDGE_IDLE = 2'b00,
    EDGE_HIGH = 2'b01,
    EDGE_LOW  = 2'b10
  } ttm_edge_t;
endpackage

// ### hw/ttm_fall_det.sv
/*
  ttm_fall_det: synchronises one pin and flags a high-to-low change
  seen between two sampling enables.
  assumes pin levels are synchronous to ref_clk.
*/
`timescale 1ns/1ps
module ttm_fall_det
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // sampling
  input  wire logic sample_en,
  input  wire logic pin_in,
  // result
  output logic      level,
  output logic      fall
);
  logic                 sync1_reg;
  logic                 sync2_reg;
  ttm_pkg::ttm_edge_t   state_reg;
  ttm_pkg::ttm_edge_t   state_next;
  logic                 fall_next;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    fall_next  = 1'b0;
    if (sample_en)
    begin
      case (state_reg)
        ttm_pkg::EDGE_IDLE: state_next = sync2_reg ? ttm_pkg::EDGE_HIGH : ttm_pkg::EDGE_LOW;
        ttm_pkg::EDGE_HIGH:
        begin
          if (!sync2_reg)
          begin
            state_next = ttm_pkg::EDGE_LOW;
            fall_next  = 1'b1;
          end
        end
        ttm_pkg::EDGE_LOW: state_next = sync2_reg ? ttm_pkg::EDGE_HIGH : ttm_pkg::EDGE_LOW;
        default: state_next = ttm_pkg::EDGE_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= ttm_pkg::EDGE_IDLE;
      fall      <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      fall      <= fall_next;
    end
  end

  assign level = sync2_reg;
endmodule

// ### hw/ttm_timer_two.sv
/*
  ttm_timer_two: timer two control and mode logic with counter,
  capture/reload and serial baud clock selection.
  assumes a one-cycle strobed register port and pins on ref_clk.
*/
// How it works
// - receive-select 1 routes this overflow to serial receive clock, else other timer
// - transmit-select 1 routes this overflow to serial transmit clock, else other timer
// - trigger enabled, not baud mode and not up/down mode: trigger fall causes capture or reload
// - trigger enable 0: trigger pin falls cause nothing; the pin level still sets the up/down direction
// - run field 1 counts, 0 stops; software sets it separately
// - source 0 counts internal machine cycles, osc/12 or osc/6; osc/2 or osc in baud mode
// - source 1 counts falling edges of the count pin
// - capture select with trigger enable copies count on trigger fall
// - capture select clear reloads on overflow, and on trigger fall if enabled
// - any serial clock select forces reload on overflow, capture ignored
// - mode bit 0 enables up/down counting
// - up/down: trigger high counts up, low counts down
// - mode bits 7 to 2 read as zero; only bits 1 and 0 hold state
// - mode register at 0C9H, low two bits reset to zero
`timescale 1ns/1ps
module ttm_timer_two
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        six_clock_mode,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // pins
  input  wire logic        trigger_pin,
  input  wire logic        count_input_pin,
  // serial port baud clocks
  input  wire logic        other_timer_ovf,
  output logic             rx_baud_tick,
  output logic             tx_baud_tick,
  // status
  output logic             output_enable,
  output logic             overflow_pulse
);
  logic [7:0]  ctrl_reg;
  logic [1:0]  mode_reg;
  logic [15:0] cap_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [3:0]  div_reg;
  logic [7:0]  rdata_next;
  logic        ovf_reg;
  logic        ovf_flag_next;
  logic        ext_flag_next;
  logic        trig_level;
  logic        trig_fall;
  logic        cnt_fall;

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == ttm_pkg::CTRL_ADDR);
  wire wr_mode = reg_wr && (reg_addr == ttm_pkg::MODE_ADDR);
  wire wr_capl = reg_wr && (reg_addr == ttm_pkg::CAPL_ADDR);
  wire wr_caph = reg_wr && (reg_addr == ttm_pkg::CAPH_ADDR);
  wire wr_cntl = reg_wr && (reg_addr == ttm_pkg::CNTL_ADDR);
  wire wr_cnth = reg_wr && (reg_addr == ttm_pkg::CNTH_ADDR);

  // control fields
  wire rx_sel   = ctrl_reg[ttm_pkg::CTRL_RX_SEL];
  wire tx_sel   = ctrl_reg[ttm_pkg::CTRL_TX_SEL];
  wire trig_en  = ctrl_reg[ttm_pkg::CTRL_TRIG_EN];
  wire run      = ctrl_reg[ttm_pkg::CTRL_RUN];
  wire src_ext  = ctrl_reg[ttm_pkg::CTRL_SRC];
  wire cap_sel  = ctrl_reg[ttm_pkg::CTRL_CAPSEL];
  wire down_en  = mode_reg[ttm_pkg::MODE_DOWN_EN];
  wire baud_mode = rx_sel || tx_sel;

  // internal clock enable divider
  wire [3:0] div_top = baud_mode ? (six_clock_mode ? ttm_pkg::BDIV_6 : ttm_pkg::BDIV_12)
                                 : (six_clock_mode ? ttm_pkg::DIV_6 : ttm_pkg::DIV_12);
  wire       int_tick = (div_reg >= div_top);

  always_ff @(posedge ref_clk)
  begin
    if (srst || int_tick)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  ttm_fall_det u_trig
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .sample_en (int_tick),
    .pin_in    (trigger_pin),
    .level     (trig_level),
    .fall      (trig_fall)
  );

  ttm_fall_det u_cnt
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .sample_en (int_tick),
    .pin_in    (count_input_pin),
    .level     (),
    .fall      (cnt_fall)
  );

  wire step = run && (src_ext ? cnt_fall : int_tick);

  wire updown   = down_en && !baud_mode;
  wire count_dn = updown && !trig_level;
  wire hit_top  = (cnt_reg == ttm_pkg::CNT_TOP);
  wire hit_low  = (cnt_reg == cap_reg);
  wire wrap     = step && (count_dn ? hit_low : hit_top);

  // no trigger capture or reload in baud mode; trigger fall still sets the flag
  wire trig_evt = trig_en && trig_fall && !updown;
  wire trig_act = trig_evt && !baud_mode;
  // capture select ignored in baud mode
  wire do_cap   = trig_act && cap_sel;
  // reload on overflow or trigger fall
  wire do_rld   = (wrap && (!cap_sel || baud_mode) && !count_dn) || (trig_act && !cap_sel);

  assign cnt_next = (wrap && count_dn) ? ttm_pkg::CNT_TOP
                  : do_rld ? cap_reg
                  : step ? (count_dn ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001)
                  : cnt_reg;

  // flags: set wins over software clear
  assign ovf_flag_next = (wrap && !baud_mode)
                       || (wr_ctrl ? reg_wdata[ttm_pkg::CTRL_OVF_FLAG] : ctrl_reg[ttm_pkg::CTRL_OVF_FLAG]);
  wire   ext_cur       = wr_ctrl ? reg_wdata[ttm_pkg::CTRL_EXT_FLAG] : ctrl_reg[ttm_pkg::CTRL_EXT_FLAG];
  assign ext_flag_next = trig_evt || (updown && wrap ? !ext_cur : ext_cur);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ctrl_reg <= ttm_pkg::CTRL_RESET;
    else
      ctrl_reg <= {ovf_flag_next, ext_flag_next,
                   wr_ctrl ? reg_wdata[5:0] : ctrl_reg[5:0]};
  end

  // mode register, two bits reset to zero
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      mode_reg <= ttm_pkg::MODE_RESET;
    else if (wr_mode)
      mode_reg <= reg_wdata[1:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cap_reg <= ttm_pkg::CNT_RESET;
    else if (do_cap)
      cap_reg <= cnt_reg;
    else
      cap_reg <= {wr_caph ? reg_wdata : cap_reg[15:8], wr_capl ? reg_wdata : cap_reg[7:0]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cnt_reg <= ttm_pkg::CNT_RESET;
    else if (wr_cntl || wr_cnth)
      cnt_reg <= {wr_cnth ? reg_wdata : cnt_reg[15:8], wr_cntl ? reg_wdata : cnt_reg[7:0]};
    else
      cnt_reg <= cnt_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ovf_reg <= 1'b0;
    else
      ovf_reg <= wrap;
  end

  // read mux
  // reserved mode bits read as zero
  always_comb
  begin
    case (reg_addr)
      ttm_pkg::CTRL_ADDR: rdata_next = ctrl_reg;
      ttm_pkg::MODE_ADDR: rdata_next = {6'h00, mode_reg};
      ttm_pkg::CAPL_ADDR: rdata_next = cap_reg[7:0];
      ttm_pkg::CAPH_ADDR: rdata_next = cap_reg[15:8];
      ttm_pkg::CNTL_ADDR: rdata_next = cnt_reg[7:0];
      ttm_pkg::CNTH_ADDR: rdata_next = cnt_reg[15:8];
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 8'h00;
  end

  assign rx_baud_tick = rx_sel ? ovf_reg : other_timer_ovf;
  assign tx_baud_tick = tx_sel ? ovf_reg : other_timer_ovf;

  assign output_enable  = mode_reg[ttm_pkg::MODE_OUT_EN];
  assign overflow_pulse = ovf_reg;
endmodule

// ### test/ttm_far.sv
/*
  serial port side: other timer overflow source, tick counters
  assumes one-cycle ticks on ref_clk
*/
`timescale 1ns/1ps
module ttm_far
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clr,
  // baud ticks
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  input  wire logic overflow_pulse,
  output logic      other_timer_ovf
);
  logic [2:0] div_reg;
  int         rx_n, tx_n, ovf_n, oth_n;
  always_ff @(posedge ref_clk)
  begin
    div_reg <= (srst || div_reg == 3'h6) ? 3'h0 : div_reg + 3'h1;
    other_timer_ovf <= !srst && div_reg == 3'h6;
  end
  always_ff @(posedge ref_clk)
  begin
    rx_n <= clr ? 0 : rx_n + int'(rx_baud_tick);
    tx_n <= clr ? 0 : tx_n + int'(tx_baud_tick);
    ovf_n <= clr ? 0 : ovf_n + int'(overflow_pulse);
    oth_n <= clr ? 0 : oth_n + int'(other_timer_ovf);
  end
endmodule

// ### test/ttm_timer_two_asserts.sv
/*
  port checks for ttm_timer_two
  assumes bind to the design top
*/
`timescale 1ns/1ps
module ttm_asserts
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // ticks
  input wire logic       other_timer_ovf,
  input wire logic       rx_baud_tick,
  input wire logic       tx_baud_tick,
  input wire logic       output_enable,
  input wire logic       overflow_pulse
);
  logic [7:0] ctrl_reg;
  logic [1:0] mode_reg;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_reg <= 8'h00;
      mode_reg <= 2'h0;
    end
    else if (reg_wr && reg_addr == 8'hC8)
      ctrl_reg <= reg_wdata;
    else if (reg_wr && reg_addr == 8'hC9)
      mode_reg <= reg_wdata[1:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rx; rx_baud_tick == (ctrl_reg[5] ? overflow_pulse : other_timer_ovf); endproperty
  a_rx: assert property (p_rx) else $error("rx source");
  property p_tx; tx_baud_tick == (ctrl_reg[4] ? overflow_pulse : other_timer_ovf); endproperty
  a_tx: assert property (p_tx) else $error("tx source");
  property p_stop; (!ctrl_reg[2]) [*3] |-> !overflow_pulse; endproperty
  a_stop: assert property (p_stop) else $error("stopped");
  property p_ctrl; reg_rd && reg_addr == 8'hC8 |=> reg_rdata[5:0] == ctrl_reg[5:0]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl");
  property p_mode; reg_rd && reg_addr == 8'hC9 |=> reg_rdata == {6'h00, mode_reg}; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_oe; output_enable == mode_reg[1]; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_unmap; reg_rd && (reg_addr < 8'hC8 || reg_addr > 8'hCD) |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  c_rx: cover property (ctrl_reg[5] && rx_baud_tick);
  c_ovf: cover property (!ctrl_reg[5] && overflow_pulse);
  c_oe: cover property (output_enable);
endmodule
bind ttm_timer_two ttm_asserts u_ttm_asserts
(
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .other_timer_ovf(other_timer_ovf), .rx_baud_tick(rx_baud_tick),
  .tx_baud_tick(tx_baud_tick), .output_enable(output_enable), .overflow_pulse(overflow_pulse)
);

// ### test/tb.sv
/*
  register-level tests of ttm_timer_two
  assumes 100 MHz ref_clk, both 12-clock and 6-clock modes
*/
`timescale 1ns/1ps
module tb;
  logic       ref_clk, srst, reg_wr, reg_rd, trigger_pin, clr, rx, tx, oth, ovf, cpin, six, oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         bad_count, tests_run, n;
  logic [7:0] ctl [7] = '{8'h04, 8'h15, 8'h25, 8'h35, 8'h30, 8'h04, 8'h35};
  int         rate [7] = '{10, 60, 60, 60, 0, 20, 120};
  ttm_timer_two u_ttm_timer_two
  (
    .ref_clk(ref_clk), .srst(srst), .six_clock_mode(six), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_pin(trigger_pin), .count_input_pin(cpin),
    .other_timer_ovf(oth), .rx_baud_tick(rx), .tx_baud_tick(tx), .output_enable(oe), .overflow_pulse(ovf)
  );
  ttm_far u_ttm_far
  (
    .ref_clk(ref_clk), .srst(srst), .clr(clr), .rx_baud_tick(rx), .tx_baud_tick(tx), .overflow_pulse(ovf),
    .other_timer_ovf(oth)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] s, e, input string m);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", m, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "rdata");
    @(posedge ref_clk);
  endtask
  task automatic fall(input logic c);
    if (c)
      cpin <= 1'b0;
    else
      trigger_pin <= 1'b0;
    repeat (30) @(posedge ref_clk);
    if (c)
      cpin <= 1'b1;
    else
      trigger_pin <= 1'b1;
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {bad_count, tests_run} = 0;
    {srst, clr, trigger_pin, reg_wr, reg_rd} = 5'b11100;
    {cpin, six} = 2'b10;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(8'hC8, 8'h00);
    rd(8'hC9, 8'h00);
    wr(8'hC9, 8'h03);
    rd(8'hC9, 8'h03);
    chk(oe, 8'h01, "output_enable");
    rd(8'hCE, 8'h00);
    wr(8'hC9, 8'h00);
    chk(oe, 8'h00, "output_enable");
    $display("registers done");
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    #1;
    for (n = 0; n < 60 && ovf !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk(ovf, 8'h01, "overflow");
    rd(8'hCC, 8'hF0);
    rd(8'hC8, 8'h84);
    $display("reload done");
    wr(8'hCB, 8'hAA);
    wr(8'hCD, 8'h12);
    wr(8'hC8, 8'h05);
    fall(1'b0);
    rd(8'hCB, 8'hAA);
    rd(8'hC8, 8'h05);
    wr(8'hC8, 8'h0D);
    fall(1'b0);
    rd(8'hCB, 8'h12);
    rd(8'hC8, 8'h4D);
    $display("capture done");
    wr(8'hC8, 8'h0C);
    wr(8'hCB, 8'h34);
    wr(8'hCA, 8'h56);
    fall(1'b0);
    rd(8'hCD, 8'h34);
    rd(8'hC8, 8'h4C);
    wr(8'hC8, 8'h1C);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    fall(1'b0);
    rd(8'hCD, 8'h00);
    rd(8'hC8, 8'h5C);
    $display("trigger reload done");
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h58);
    wr(8'hCD, 8'h34);
    wr(8'hC9, 8'h01);
    trigger_pin <= 1'b0;
    repeat (20) @(posedge ref_clk);
    wr(8'hC8, 8'h04);
    repeat (60) @(posedge ref_clk);
    rd(8'hCD, 8'hFF);
    trigger_pin <= 1'b1;
    repeat (150) @(posedge ref_clk);
    rd(8'hCD, 8'h34);
    rd(8'hC8, 8'h84);
    wr(8'hC9, 8'h00);
    $display("up down done");
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h06);
    repeat (5) fall(1'b1);
    rd(8'hCC, 8'h05);
    $display("event count done");
    wr(8'hCA, 8'hFF);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      six <= (i > 4);
      wr(8'hC8, ctl[i]);
      clr <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clr <= 1'b0;
      repeat (120) @(posedge ref_clk);
      #1;
      chk(8'(u_ttm_far.rx_n), 8'(ctl[i][5] ? u_ttm_far.ovf_n : u_ttm_far.oth_n), "rx");
      chk(8'(u_ttm_far.tx_n), 8'(ctl[i][4] ? u_ttm_far.ovf_n : u_ttm_far.oth_n), "tx");
      n = u_ttm_far.ovf_n - rate[i];
      chk(8'(n > -2 && n < 2), 8'h01, "rate");
    end
    $display("baud done");
    finish_test();
  end
endmodule
